// *** dp_host_defines.svh ***
// constants for the dual-port port controller: offsets, fields, timing
// assumes a 100 MHz clock; times are in picoseconds
`ifndef DP_HOST_DEFINES_SVH
`define DP_HOST_DEFINES_SVH

// register word offsets on the apb side
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_WDATA_HI 8'h0c
`define REG_LANES 8'h10
`define REG_RDATA 8'h14
`define REG_RDATA_HI 8'h18
`define REG_STATUS 8'h1c

// control fields
`define CTRL_START_BIT 0
`define CTRL_OP_LSB 1
`define CTRL_OP_MSB 2
// status fields
`define ST_ACTIVE_BIT 0
`define ST_DONE_BIT 1
`define ST_INT_BIT 2
`define ST_BUSYPIN_BIT 3
`define ST_OWNED_BIT 4
`define LANES_RESET 4'hf

// timing figures as printed (slowest grade), in ps
`define CLK_PERIOD_PS 10000
`define WRITE_DATA_SETUP_PS 15000
`define SELECT_ACCESS_TIME_PS 20000
`define FLAG_DELAY_FROM_SELECT_PS 20000
`define TOKEN_RECOVERY_PULSE_PS 10000
`define TOKEN_WRITE_TO_READ_PS 5000
// two synchroniser stages in front of every sampled pin
`define SYNC_STAGES 2

// least waits round up to whole cycles
`define CEIL_CYC(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETTLE_CYC (`CEIL_CYC(`FLAG_DELAY_FROM_SELECT_PS) + `SYNC_STAGES)
`define WSETUP_CYC `CEIL_CYC(`WRITE_DATA_SETUP_PS)
`define RECOV_CYC (`CEIL_CYC(`TOKEN_RECOVERY_PULSE_PS) + \
   `CEIL_CYC(`TOKEN_WRITE_TO_READ_PS))
`define READ_CYC (`CEIL_CYC(`SELECT_ACCESS_TIME_PS) + `SYNC_STAGES)

`endif

// *** dp_host_pkg.sv ***
// types for the dual-port port controller
// assumes dp_host_defines.svh carries all numbers
package dp_host_pkg;
   // operations software may start
   typedef enum logic [1:0] {
      OP_MEM_READ = 2'h0,
      OP_MEM_WRITE = 2'h1,
      OP_TOKEN_WRITE = 2'h2,
      OP_TOKEN_READ = 2'h3
   } op_t;
   // pin sequencer states, one-hot
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_ADDR = 5'h02,
      S_WRITE = 5'h04,
      S_RECOV = 5'h08,
      S_READ = 5'h10
   } state_t;
endpackage : dp_host_pkg

// *** dp_port_host.sv ***
// one-port controller for an asynchronous dual-port ram with mailbox and
// token latches; software drives it over apb
// assumes one 100 MHz clock; device pins are asynchronous to it
//
// Functional notes
// - strobe held high while address changes
// - write data stable for setup before strobe rises
// - cross-port read valid after flowthrough delay
// - memory reads assert output enable and chip select
// - delay slave writes until busy settles
// - token access: token select low, chip idle
// - recovery pulse before token read-back
// - write zero, read back zero means owned
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "dp_host_defines.svh"

module dp_port_host #(
   parameter int AW = 15, // address width (32K depth)
   parameter int DW = 36 // data width
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [AW-1:0] addrOut,
   output logic [DW-1:0] dataOut,
   output logic [DW-1:0] dataOe,
   input wire logic [DW-1:0] dataIn,
   output logic portSelectLowTermN,
   output logic portSelectHighTerm,
   output logic tokenLatchSelectN,
   output logic [3:0] byteLaneSelectN,
   output logic readNotWrite,
   output logic outputEnableN,
   input wire logic busyN,
   input wire logic intN
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [DW-1:0] dataMeta_r; // first stage, read only by second
   logic [DW-1:0] dataSync_r; // sampled data bus
   logic [1:0] flagMeta_r; // first stage of busy and int
   logic [1:0] flagSync_r; // {busy active, int active}

   // two flops in front of every pin input
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dataMeta_r <= '0;
         dataSync_r <= '0;
         flagMeta_r <= 2'h0;
         flagSync_r <= 2'h0;
      end else begin
         dataMeta_r <= dataIn;
         dataSync_r <= dataMeta_r;
         flagMeta_r <= {~busyN, ~intN};
         flagSync_r <= flagMeta_r;
      end
   end
   wire busyHit = flagSync_r[1]; // arbitration lost on this port
   wire intSeen = flagSync_r[0]; // mailbox flag pending

   ////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, answer registered
   logic [AW-1:0] addr_r; // target word or token index
   logic [DW-1:0] wdata_r; // write value
   logic [3:0] lanes_r; // byte lanes enabled, active high
   logic [DW-1:0] rdata_r; // last read result
   logic done_r; // sticky: operation finished
   logic owned_r; // last token read returned zero
   dp_host_pkg::op_t op_r; // operation in flight
   dp_host_pkg::state_t state_r;
   dp_host_pkg::state_t state_nxt;
   logic [3:0] cnt_r; // phase counter
   logic [3:0] cnt_nxt;

   wire access = psel & penable; // access phase
   wire commit = access & pready; // edge at which the transfer ends
   wire wrCommit = commit & pwrite;
   wire idle = (state_r == dp_host_pkg::S_IDLE);
   wire [7:0] off = paddr;
   wire hitCtrl = (off == `REG_CTRL);
   wire mapped = hitCtrl | (off == `REG_ADDR) | (off == `REG_WDATA) |
      (off == `REG_WDATA_HI) | (off == `REG_LANES) |
      (off == `REG_RDATA) | (off == `REG_RDATA_HI) | (off == `REG_STATUS);
   // start is refused while an operation runs
   wire start = wrCommit & hitCtrl & pwdata[`CTRL_START_BIT] & idle;
   wire [31:0] statusWord = {27'h0, owned_r, busyHit, intSeen, done_r,
      ~idle};
   wire [31:0] readMux =
      (off == `REG_ADDR) ? {{(32-AW){1'b0}}, addr_r} :
      (off == `REG_WDATA) ? wdata_r[31:0] :
      (off == `REG_WDATA_HI) ? {28'h0, wdata_r[DW-1:32]} :
      (off == `REG_LANES) ? {28'h0, lanes_r} :
      (off == `REG_RDATA) ? rdata_r[31:0] :
      (off == `REG_RDATA_HI) ? {28'h0, rdata_r[DW-1:32]} :
      (off == `REG_STATUS) ? statusWord :
      (hitCtrl) ? {29'h0, op_r, 1'b0} : 32'h0;

   // answer one cycle into the access phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= access & ~pready;
         prdata <= (access & ~pready & ~pwrite) ? readMux : 32'h0;
         pslverr <= access & ~pready & ~mapped;
      end
   end

   // software registers; writes land only at the committing edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_r <= '0;
         wdata_r <= '0;
         lanes_r <= `LANES_RESET;
         op_r <= dp_host_pkg::OP_MEM_READ;
      end else if (wrCommit & idle) begin
         if (off == `REG_ADDR) addr_r <= pwdata[AW-1:0];
         if (off == `REG_WDATA) wdata_r[31:0] <= pwdata;
         if (off == `REG_WDATA_HI) wdata_r[DW-1:32] <= pwdata[3:0];
         if (off == `REG_LANES) lanes_r <= pwdata[3:0];
         if (hitCtrl) begin
            op_r <= dp_host_pkg::op_t'(
               pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin sequencer
   wire isWrite = (op_r == dp_host_pkg::OP_MEM_WRITE) |
      (op_r == dp_host_pkg::OP_TOKEN_WRITE);
   wire isToken = (op_r == dp_host_pkg::OP_TOKEN_WRITE) |
      (op_r == dp_host_pkg::OP_TOKEN_READ);
   wire cntDone = (cnt_r == 4'h0);

   function automatic logic [3:0] cyc(input int n);
      cyc = 4'(n - 1);
   endfunction : cyc

   // next state and phase counts
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cntDone ? 4'h0 : cnt_r - 4'h1;
      unique case (state_r)
         dp_host_pkg::S_IDLE: begin
            cnt_nxt = cyc(`SETTLE_CYC);
            if (start) state_nxt = dp_host_pkg::S_ADDR;
         end
         dp_host_pkg::S_ADDR: begin
            // busy flag gets its settle time; a lost memory write waits, token writes do not
            if (cntDone & ~(isWrite & ~isToken & busyHit)) begin
               state_nxt = isWrite ? dp_host_pkg::S_WRITE :
                  dp_host_pkg::S_READ;
               cnt_nxt = isWrite ? cyc(`WSETUP_CYC) : cyc(`READ_CYC);
            end
         end
         dp_host_pkg::S_WRITE: begin
            // data held for the setup time before the strobe rises
            if (cntDone) begin
               state_nxt = dp_host_pkg::S_RECOV;
               cnt_nxt = cyc(`RECOV_CYC);
            end
         end
         dp_host_pkg::S_RECOV: begin
            // selects idle before any read-back
            if (cntDone) state_nxt = dp_host_pkg::S_IDLE;
         end
         dp_host_pkg::S_READ: begin
            // window spans access time plus both sync stages
            if (cntDone) state_nxt = dp_host_pkg::S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= dp_host_pkg::S_IDLE;
         cnt_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // pin levels decoded from the next state, then registered
   wire nAddr = (state_nxt == dp_host_pkg::S_ADDR);
   wire nWrite = (state_nxt == dp_host_pkg::S_WRITE);
   wire nRead = (state_nxt == dp_host_pkg::S_READ);
   wire nSel = nAddr | nWrite | nRead;
   wire memSel = nSel & ~isToken;
   wire tokSel = nSel & isToken;
   wire [DW-1:0] tokData = {{(DW-1){1'b1}}, wdata_r[0]};

   // drive device pins; strobe only falls after address is steady
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addrOut <= '0;
         dataOut <= '0;
         dataOe <= '0;
         portSelectLowTermN <= 1'b1;
         portSelectHighTerm <= 1'b0;
         tokenLatchSelectN <= 1'b1;
         byteLaneSelectN <= 4'hf;
         readNotWrite <= 1'b1;
         outputEnableN <= 1'b1;
      end else begin
         if (start) addrOut <= addr_r;
         dataOut <= isToken ? tokData : wdata_r;
         dataOe <= nWrite ? '1 : '0;
         portSelectLowTermN <= ~memSel;
         portSelectHighTerm <= memSel;
         tokenLatchSelectN <= ~tokSel;
         byteLaneSelectN <= memSel ? ~lanes_r : 4'hf;
         readNotWrite <= ~nWrite;
         outputEnableN <= ~nRead;
      end
   end

   // capture results and completion
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r <= '0;
         done_r <= 1'b0;
         owned_r <= 1'b0;
      end else begin
         if (state_r == dp_host_pkg::S_READ && cntDone) begin
            rdata_r <= dataSync_r;
            if (isToken) owned_r <= ~dataSync_r[0];
         end
         // completion set wins over the clear at a new start
         if (~idle && state_nxt == dp_host_pkg::S_IDLE) begin
            done_r <= 1'b1;
         end else if (start) begin
            done_r <= 1'b0;
         end
      end
   end
endmodule : dp_port_host

// *** dp_port_host_sva.sv ***
// checker for the port controller's device-side pin sequencing
// assumes it is bound to dp_port_host; one clock, async reset
`timescale 1ns/1ps
module dp_port_host_sva #(
   parameter int AW = 15,
   parameter int DW = 36
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [AW-1:0] addrOut,
   input wire logic [DW-1:0] dataOut,
   input wire logic [DW-1:0] dataOe,
   input wire logic portSelectLowTermN,
   input wire logic portSelectHighTerm,
   input wire logic tokenLatchSelectN,
   input wire logic [3:0] byteLaneSelectN,
   input wire logic readNotWrite,
   input wire logic outputEnableN
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   a_addr_strobe_high: assert property (
      !$stable(addrOut) |-> readNotWrite)
      else $error("address moved while strobe low");
   a_setup_before_end: assert property (
      $rose(readNotWrite) |-> $past(!readNotWrite && dataOe[0], 2))
      else $error("write strobe shorter than data setup");
   a_data_held: assert property (
      !readNotWrite && $past(!readNotWrite) |-> $stable(dataOut))
      else $error("write data moved during strobe");
   a_settle_first: assert property (
      $fell(readNotWrite) |->
      $past(!portSelectLowTermN || !tokenLatchSelectN, 4))
      else $error("write began before busy settled");
   a_read_selected: assert property (
      !outputEnableN |->
      (!portSelectLowTermN && portSelectHighTerm) || !tokenLatchSelectN)
      else $error("output enable without a select");
   a_read_undriven: assert property (
      !outputEnableN |-> dataOe == '0)
      else $error("data driven during a read");
   a_token_chip_idle: assert property (
      !tokenLatchSelectN |-> portSelectLowTermN && !portSelectHighTerm &&
      byteLaneSelectN == 4'hf)
      else $error("chip select active during token access");
   a_token_recovery: assert property (
      $rose(tokenLatchSelectN) |-> tokenLatchSelectN [*3])
      else $error("token select recovery too short");
   a_token_bit_zero: assert property (
      !tokenLatchSelectN && !readNotWrite |-> dataOut[DW-1:1] == '1)
      else $error("token write drives more than bit zero");
   // main scenarios reached
   cover property ($fell(readNotWrite) && tokenLatchSelectN);
   cover property (!outputEnableN && !tokenLatchSelectN);
   cover property (pready && pslverr);
endmodule : dp_port_host_sva
bind dp_port_host dp_port_host_sva #(.AW(AW), .DW(DW)) chk_u (
   .clk(clk), .rst(rst), .pready(pready), .pslverr(pslverr),
   .addrOut(addrOut), .dataOut(dataOut), .dataOe(dataOe),
   .portSelectLowTermN(portSelectLowTermN),
   .portSelectHighTerm(portSelectHighTerm),
   .tokenLatchSelectN(tokenLatchSelectN),
   .byteLaneSelectN(byteLaneSelectN), .readNotWrite(readNotWrite),
   .outputEnableN(outputEnableN));

// *** dp_port_model.sv ***
// behavioural model of one port of the dual-port ram with tokens
// assumes clk only paces updates; the far port is driven by the bench
`timescale 1ns/1ps
module dp_port_model #(
   parameter int AW = 15
) (
   input wire logic clk,
   input wire logic [AW-1:0] addrOut,
   input wire logic [35:0] dataOut,
   output logic [35:0] dataIn,
   input wire logic portSelectLowTermN,
   input wire logic portSelectHighTerm,
   input wire logic tokenLatchSelectN,
   input wire logic [3:0] byteLaneSelectN,
   input wire logic readNotWrite,
   input wire logic outputEnableN,
   output logic busyN,
   output logic intN,
   input wire logic holdBusy, // far port wins arbitration
   input wire logic mailIn, // far port writes our mailbox
   input wire logic [7:0] farHold // tokens held by far port
);
   logic [35:0] mem [0:(1<<AW)-1];
   logic [7:0] own = '0; // tokens held here
   logic [7:0] req = '0; // requests waiting here
   logic tick = 1'b0;
   logic intFlag = 1'b1; // mailbox flag, active low
   wire memSel = !portSelectLowTermN && portSelectHighTerm &&
      tokenLatchSelectN;
   // tokens with chip select idle, or with all lanes high
   wire tokSel = !tokenLatchSelectN &&
      (portSelectLowTermN || &byteLaneSelectN);
   wire [2:0] tk = addrOut[2:0];
   wire [AW-1:0] ownBox = {{(AW-1){1'b1}}, 1'b0};
   wire drive = readNotWrite && !outputEnableN && (memSel || tokSel);
   assign busyN = !holdBusy;
   assign intN = intFlag;
   // released lines toggle so a stale value is never seen
   assign dataIn = !drive ? {36{tick}} ^ 36'h5a5a5a5a5 :
      tokSel ? {27'h0, {9{!own[tk]}}} : mem[addrOut];
   always @(posedge clk) begin
      tick <= !tick;
      if (mailIn)
         intFlag <= 1'b0;
      if (drive && memSel && addrOut == ownBox && busyN)
         intFlag <= 1'b1;
      for (int i = 0; i < 8; i++)
         if (req[i] && !farHold[i]) begin
            own[i] <= 1'b1;
            req[i] <= 1'b0;
         end
      if (!readNotWrite && memSel && busyN)
         for (int i = 0; i < 4; i++)
            if (!byteLaneSelectN[i])
               mem[addrOut][9*i+:9] <= dataOut[9*i+:9];
      if (!readNotWrite && tokSel && !dataOut[0]) begin
         own[tk] <= !farHold[tk];
         req[tk] <= farHold[tk];
      end
      if (!readNotWrite && tokSel && dataOut[0]) begin
         own[tk] <= 1'b0;
         req[tk] <= 1'b0;
      end
   end
endmodule : dp_port_model

// *** dual_port_ram_arbitration_bench.sv ***
// bench: apb tasks drive the controller against the port model
// assumes the defines header is on the include path
`timescale 1ns/1ps
`include "dp_host_defines.svh"
module dual_port_ram_arbitration_bench;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, holdBusy = 0, mailIn = 0;
   logic [14:0] addrOut;
   logic [35:0] dataOut, dataOe, dataIn, d;
   logic portSelectLowTermN, portSelectHighTerm, tokenLatchSelectN;
   logic [3:0] byteLaneSelectN;
   logic readNotWrite, outputEnableN, busyN, intN;
   logic [7:0] farHold = '0;
   int mismatches = 0, checks = 0;
   dp_port_host dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .addrOut(addrOut),
      .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
      .portSelectLowTermN(portSelectLowTermN),
      .portSelectHighTerm(portSelectHighTerm),
      .tokenLatchSelectN(tokenLatchSelectN),
      .byteLaneSelectN(byteLaneSelectN), .readNotWrite(readNotWrite),
      .outputEnableN(outputEnableN), .busyN(busyN), .intN(intN));
   dp_port_model far_u (.clk(clk), .addrOut(addrOut), .dataOut(dataOut),
      .dataIn(dataIn), .portSelectLowTermN(portSelectLowTermN),
      .portSelectHighTerm(portSelectHighTerm),
      .tokenLatchSelectN(tokenLatchSelectN),
      .byteLaneSelectN(byteLaneSelectN), .readNotWrite(readNotWrite),
      .outputEnableN(outputEnableN), .busyN(busyN), .intN(intN),
      .holdBusy(holdBusy), .mailIn(mailIn), .farHold(farHold));
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (mismatches == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [35:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one apb transfer; read data and error land in rd and err
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] v);
      int n = 0;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 20) begin
         mismatches++;
         end_sim();
      end
   endtask : apb
   // poll status until done; status stays in rd
   task automatic fin();
      int n = 0;
      do begin
         apb(0, `REG_STATUS, 0);
         n++;
      end while (rd[`ST_DONE_BIT] !== 1'b1 && n < 40);
      chk("done", n < 40, 1);
      if (n >= 40) end_sim();
   endtask : fin
   task automatic run(input dp_host_pkg::op_t op);
      apb(1, `REG_CTRL, {29'h0, op, 1'b1});
      fin();
   endtask : run
   task automatic put(input logic [14:0] a, input logic [35:0] v,
      input logic [3:0] ln);
      apb(1, `REG_ADDR, {17'h0, a});
      apb(1, `REG_WDATA, v[31:0]);
      apb(1, `REG_WDATA_HI, {28'h0, v[35:32]});
      apb(1, `REG_LANES, {28'h0, ln});
   endtask : put
   task automatic get(input logic [14:0] a);
      put(a, '0, 4'hf);
      run(dp_host_pkg::OP_MEM_READ);
      apb(0, `REG_RDATA, 0);
      d[31:0] = rd;
      apb(0, `REG_RDATA_HI, 0);
      d[35:32] = rd[3:0];
      apb(0, `REG_STATUS, 0);
   endtask : get
   task automatic tok(input logic [14:0] a, input logic b, input logic ex);
      put(a, {35'h0, b}, 4'hf);
      run(dp_host_pkg::OP_TOKEN_WRITE);
      run(dp_host_pkg::OP_TOKEN_READ);
      chk("owned", rd[`ST_OWNED_BIT], ex);
   endtask : tok
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst <= 0;
      apb(0, `REG_LANES, 0);
      chk("lanes", rd, `LANES_RESET);
      apb(0, 8'h20, 0);
      chk("unmapped", {err, rd}, 36'h100000000);
      put(15'h0005, 36'h91234abcd, 4'hf);
      run(dp_host_pkg::OP_MEM_WRITE);
      put(15'h0005, 36'h0000000ee, 4'h1);
      run(dp_host_pkg::OP_MEM_WRITE);
      get(15'h0005);
      chk("word", d, 36'h91234aaee);
      // far port wins: our write must wait for busy to clear
      holdBusy <= 1;
      put(15'h0006, 36'h0fedcba98, 4'hf);
      apb(1, `REG_CTRL, {29'h0, dp_host_pkg::OP_MEM_WRITE, 1'b1});
      repeat (30) @(posedge clk);
      apb(0, `REG_STATUS, 0);
      chk("held", {rd[`ST_ACTIVE_BIT], readNotWrite}, 2'b11);
      holdBusy <= 0;
      fin();
      get(15'h0006);
      chk("word", d, 36'h0fedcba98);
      // mailbox flag from the far port
      mailIn <= 1;
      @(posedge clk);
      mailIn <= 0;
      get(15'h7fff);
      chk("flag", rd[`ST_INT_BIT], 1);
      holdBusy <= 1;
      get(15'h7ffe);
      chk("flag", rd[`ST_INT_BIT], 1);
      holdBusy <= 0;
      get(15'h7ffe);
      chk("flag", rd[`ST_INT_BIT], 0);
      // tokens: acquire, contend, hand over, release
      farHold <= 8'h20;
      tok(15'h7ff3, 0, 1);
      tok(15'h0005, 0, 0);
      farHold <= 8'h00;
      run(dp_host_pkg::OP_TOKEN_READ);
      chk("owned", rd[`ST_OWNED_BIT], 1);
      tok(15'h0005, 1, 0);
      tok(15'h0003, 1, 0);
      end_sim();
   end
endmodule : dual_port_ram_arbitration_bench
